// ### common/adg_pkg.sv
package adg_pkg;

	// Register indices; each register owns one aligned word at four times its index.
	localparam logic [7:0] IDX_RESULT_HIGH = 8'he4;
	localparam logic [7:0] IDX_RESULT_LOW = 8'he5;
	localparam logic [7:0] IDX_CONTROL = 8'he6;
	localparam logic [7:0] IDX_SECOND_CONTROL = 8'he7;
	localparam logic [7:0] IDX_STATUS = 8'he8;

	// Byte addresses on the AXI4-Lite slave.
	localparam logic [9:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
	localparam logic [9:0] ADDR_RESULT_LOW = {IDX_RESULT_LOW, 2'b00};
	localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [9:0] ADDR_SECOND_CONTROL = {IDX_SECOND_CONTROL, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	// Field positions of gate_and_source_control.
	localparam int GATE_EN_MSB = 7;
	localparam int GATE_EN_LSB = 4;
	localparam int GATE_SRC0_BIT = 3;
	localparam int COL_SEL_MSB = 2;
	localparam int COL_SEL_LSB = 1;
	localparam int LATCH_SRC0_BIT = 0;

	// Field positions of second_control_register.
	localparam int SC_INVERT_LATCH_BIT = 6;
	localparam int SC_GATE_SRC_MSB = 5;
	localparam int SC_GATE_SRC_LSB = 3;
	localparam int SC_LATCH_SRC_MSB = 2;
	localparam int SC_LATCH_SRC_LSB = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] SECOND_CONTROL_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Code to block number (row*4+position) for the 16 select codes.
	localparam logic [63:0] BLOCK_MAP = 64'hfbc8_d9ea_7340_5162;

	typedef struct packed {
		logic [3:0] gate_en;
		logic gate_src0;
		logic [1:0] col_sel;
		logic latch_src0;
	} adg_control_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} adg_result_t;

endpackage

// ### hw/adg_block_select.sv
`timescale 1ns/100ps
`default_nettype none

// Maps a four-bit select code onto one of sixteen digital block lines.
module adg_block_select
(
	input wire logic [3:0] code,
	input wire logic [15:0] blocks,
	output logic selected
);

	wire [3:0] block_index;

	assign block_index = adg_pkg::BLOCK_MAP[{code, 2'b00} +: 4];
	assign selected = blocks[block_index];

endmodule // adg_block_select

`default_nettype wire

// ### hw/adg_decimator_front.sv
// Operation
// - Result high read returns upper byte.
// - Result low read returns lower byte.
// - Writing either result byte clears accumulators.
// - Reset clears accumulator, status, control and output state; synchronisers are not reset.
// - Reset leaves result byte registers untouched only while the latch level is low; otherwise they load the accumulator.
// - Gate enable gates chosen column comparators.
// - One gate enable bit per column.
// - Control bit three is gate source LSB.
// - Dedicated pulse source overrides block gate.
// - Column select picks decimator comparator column.
// - Control bit zero is latch source LSB.
// - Block codes map in documented order.
`timescale 1ns/100ps
`default_nettype none

module adg_decimator_front
#(
	parameter int COLUMNS = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [COLUMNS-1:0] comparator_in,
	input wire logic [15:0] digital_blocks,
	input wire logic dedicated_pwm,
	input wire logic dedicated_pwm_enable,
	output logic [COLUMNS-1:0] gated_columns,
	output logic decimator_data,
	output logic [15:0] accumulator
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [COLUMNS-1:0] cmp_meta;
	logic [COLUMNS-1:0] cmp_sync;
	logic [15:0] blk_meta;
	logic [15:0] blk_sync;
	logic pwm_meta;
	logic pwm_sync;
	logic pwm_en_meta;
	logic pwm_en_sync;

	always_ff @(posedge aclk)
	begin
		cmp_meta <= comparator_in;
		cmp_sync <= cmp_meta;
		blk_meta <= digital_blocks;
		blk_sync <= blk_meta;
		pwm_meta <= dedicated_pwm;
		pwm_sync <= pwm_meta;
		pwm_en_meta <= dedicated_pwm_enable;
		pwm_en_sync <= pwm_en_meta;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	adg_pkg::adg_control_t control;
	logic [7:0] second_control;
	adg_pkg::adg_result_t result;
	logic result_valid;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order.

	logic aw_held;
	logic w_held;
	logic [9:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	// Each register is the low byte of its own word, so only lane 0 counts.
	wire lane_on = w_strb[0];
	wire [7:0] lane_data = w_data[7:0];
	wire wr_hit_high = aw_addr == adg_pkg::ADDR_RESULT_HIGH;
	wire wr_hit_low = aw_addr == adg_pkg::ADDR_RESULT_LOW;
	wire wr_hit_ctrl = aw_addr == adg_pkg::ADDR_CONTROL;
	wire wr_hit_sc = aw_addr == adg_pkg::ADDR_SECOND_CONTROL;
	wire wr_mapped = wr_hit_high || wr_hit_low || wr_hit_ctrl || wr_hit_sc;
	wire clear_acc = wr_fire && lane_on && (wr_hit_high || wr_hit_low);

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 10'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= adg_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? adg_pkg::RESP_OKAY : adg_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Reserved bits are stored as written; software keeps them zero.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			control <= adg_pkg::CONTROL_RESET;
			second_control <= adg_pkg::SECOND_CONTROL_RESET;
		end
		else if (wr_fire && lane_on)
		begin
			if (wr_hit_ctrl)
			begin
				control <= lane_data;
			end
			if (wr_hit_sc)
			begin
				second_control <= lane_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source selection.

	wire [3:0] gate_code = {second_control[adg_pkg::SC_GATE_SRC_MSB:adg_pkg::SC_GATE_SRC_LSB],
		control.gate_src0};
	wire [3:0] latch_code = {second_control[adg_pkg::SC_LATCH_SRC_MSB:adg_pkg::SC_LATCH_SRC_LSB],
		control.latch_src0};
	wire invert_latch = second_control[adg_pkg::SC_INVERT_LATCH_BIT];
	wire block_gate;
	wire block_latch;

	// Software only names rows that exist, so any code selects a real line.
	adg_block_select gate_select
	(
		.code(gate_code),
		.blocks(blk_sync),
		.selected(block_gate)
	);

	adg_block_select latch_select
	(
		.code(latch_code),
		.blocks(blk_sync),
		.selected(block_latch)
	);

	wire gate_source = pwm_en_sync ? pwm_sync : block_gate;
	wire latch_level = block_latch ^ invert_latch;

	// Columns absent from a smaller part are never enabled by software.
	wire [3:0] gate_en_all = control.gate_en;
	wire [COLUMNS-1:0] column_enable = gate_en_all[COLUMNS-1:0];
	wire [COLUMNS-1:0] next_gated = cmp_sync & ~(column_enable & {COLUMNS{~gate_source}});
	wire [1:0] col_sel = control.col_sel;
	wire next_data = int'(col_sel) < COLUMNS ? next_gated[col_sel] : 1'b0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gated_columns <= '0;
			decimator_data <= 1'b0;
		end
		else
		begin
			gated_columns <= next_gated;
			decimator_data <= next_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator and result latch.

	logic latch_prev;
	wire latch_edge = latch_level && !latch_prev;

	// The accumulator counts gated comparator highs; the filter itself sits elsewhere.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			accumulator <= 16'h0000;
			latch_prev <= 1'b0;
			result_valid <= 1'b0;
		end
		else
		begin
			latch_prev <= latch_level;
			if (clear_acc)
			begin
				accumulator <= 16'h0000;
			end
			else if (decimator_data)
			begin
				accumulator <= accumulator + 16'h0001;
			end
			if (latch_edge)
			begin
				result_valid <= 1'b1;
			end
		end
	end

	// No reset here: the result bytes keep their contents across reset unless latch_level is high, which reloads them.
	always_ff @(posedge aclk)
	begin
		if (latch_edge)
		begin
			result <= accumulator;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path.

	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire rd_hit_high = s_axi_araddr == adg_pkg::ADDR_RESULT_HIGH;
	wire rd_hit_low = s_axi_araddr == adg_pkg::ADDR_RESULT_LOW;
	wire rd_hit_ctrl = s_axi_araddr == adg_pkg::ADDR_CONTROL;
	wire rd_hit_sc = s_axi_araddr == adg_pkg::ADDR_SECOND_CONTROL;
	wire rd_hit_st = s_axi_araddr == adg_pkg::ADDR_STATUS;
	wire rd_mapped = rd_hit_high || rd_hit_low || rd_hit_ctrl || rd_hit_sc || rd_hit_st;
	wire [7:0] rd_value = rd_hit_high ? result.high :
		rd_hit_low ? result.low :
		rd_hit_ctrl ? control :
		rd_hit_sc ? second_control :
		rd_hit_st ? {7'h00, result_valid} : 8'h00;
	wire [31:0] rd_word = {24'h00_0000, rd_value};

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= adg_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mapped ? rd_word : 32'h0000_0000;
			s_axi_rresp <= rd_mapped ? adg_pkg::RESP_OKAY : adg_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // adg_decimator_front

`default_nettype wire

// ### verification/adg_decimator_front_checker.sv
`timescale 1ns/100ps
`default_nettype none
module adg_chk
#(
	parameter int COLUMNS = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] accumulator
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire hit_res = s_axi_awaddr == adg_pkg::ADDR_RESULT_HIGH
		|| s_axi_awaddr == adg_pkg::ADDR_RESULT_LOW;
	wire clr = tk && hit_res && s_axi_wstrb[0];
	////////////////////////////////////////////////////////////////
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready not inverse of rvalid");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	// Address and data are held one cycle before the write takes effect.
	a_b_answer: assert property (tk |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	a_acc_clear: assert property (clr |-> ##2 accumulator == 16'h0000)
		else $error("accumulator not cleared");
	a_reset_clr: assert property (disable iff (1'b0)
		!aresetn |=> accumulator == 16'h0000 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("reset left state");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == adg_pkg::RESP_SLVERR
		|-> s_axi_rdata == 32'h0000_0000)
		else $error("error read not zero");
	// One count per cycle at most; a larger jump means a stray load.
	a_acc_step: assert property (1'b1 |=> accumulator == 16'h0000
		|| 16'(accumulator - $past(accumulator)) <= 16'h0001)
		else $error("accumulator jumped");
	c_clear: cover property (clr);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == adg_pkg::RESP_SLVERR);
endmodule // adg_chk
bind adg_decimator_front adg_chk #(.COLUMNS(COLUMNS)) adg_chk_i (.*);
`default_nettype wire

// ### verification/adg_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module adg_far_side
(
	input wire logic aclk,
	input wire logic [3:0] comp_set,
	input wire logic gate_lvl,
	input wire logic latch_lvl,
	input wire logic pwm_lvl,
	input wire logic pwm_on,
	output logic [3:0] comparator_in,
	output logic [15:0] digital_blocks,
	output logic dedicated_pwm,
	output logic dedicated_pwm_enable
);
	logic [15:0] noise = 16'h0000;
	// Unused blocks toggle so a wrong block select shows up.
	always @(posedge aclk) noise <= ~noise;
	// Only block 2 (row 0, latch) and block 6 (row 1, gate) carry meaning.
	assign digital_blocks = {noise[15:7], gate_lvl, noise[5:3], latch_lvl, noise[1:0]};
	// Four columns stand here, so the gate bits of columns two and three are in use.
	assign comparator_in = comp_set;
	assign dedicated_pwm = pwm_lvl;
	assign dedicated_pwm_enable = pwm_on;
endmodule // adg_far_side
`default_nettype wire

// ### verification/adg_decimator_front_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adg_decimator_front_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, word;
	logic [3:0] s_axi_wstrb = 4'h0, comparator_in, gated_columns, comp_set = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, decimator_data;
	logic dedicated_pwm, dedicated_pwm_enable, ah, wh, bh;
	logic gate_lvl = 1'b0, latch_lvl = 1'b0, pwm_lvl = 1'b0, pwm_on = 1'b0;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] digital_blocks, accumulator;
	int fails = 0, check_count = 0, n, c;
	adg_decimator_front adg_decimator_front_i (.*);
	adg_far_side adg_far_side_i (.*);
	initial forever #10 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	task give_verdict;
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Ready is looked at on the falling edge so the handshake edge is known in advance.
	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {4{d}};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh)
			begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) fails++;
		if (n == 50) give_verdict();
	endtask
	task rd(input logic [9:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			bh = s_axi_rvalid;
			resp = s_axi_rresp;
			word = s_axi_rdata;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (bh)
			begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) fails++;
		if (n == 50) give_verdict();
	endtask
	task rchk(input logic [9:0] a, input logic [7:0] d);
		rd(a);
		chk("read", word, {24'h00_0000, d});
		chk("read resp", resp, adg_pkg::RESP_OKAY);
	endtask
	task settle;
		repeat (6) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(adg_pkg::ADDR_CONTROL, adg_pkg::CONTROL_RESET);
		for (c = 0; c < 4; c++)
		begin
			wr(adg_pkg::ADDR_CONTROL, 8'(c << 1));
			comp_set <= 4'(1 << c);
			settle();
			chk("data on", decimator_data, 1);
			comp_set <= ~4'(1 << c);
			settle();
			chk("data off", decimator_data, 0);
			rchk(adg_pkg::ADDR_CONTROL, 8'(c << 1));
		end
		for (c = 0; c < 4; c++)
		begin
			wr(adg_pkg::ADDR_CONTROL, 8'((16 << c) | 8));
			comp_set <= 4'hf;
			gate_lvl <= 1'b0;
			settle();
			chk("gated", gated_columns, ~(1 << c) & 15);
			gate_lvl <= 1'b1;
			settle();
			chk("open", gated_columns, 4'hf);
		end
		gate_lvl <= 1'b0;
		pwm_on <= 1'b1;
		pwm_lvl <= 1'b1;
		settle();
		chk("pwm open", gated_columns, 4'hf);
		pwm_lvl <= 1'b0;
		settle();
		chk("pwm shut", gated_columns, 4'h7);
		pwm_on <= 1'b0;
		wr(adg_pkg::ADDR_CONTROL, 8'h00);
		comp_set <= 4'h0;
		settle();
		wr(adg_pkg::ADDR_RESULT_HIGH, 8'h00);
		chk("clear high", accumulator, 0);
		chk("write resp", resp, adg_pkg::RESP_OKAY);
		comp_set <= 4'h1;
		repeat (300) @(posedge aclk);
		comp_set <= 4'h0;
		settle();
		chk("count", accumulator, 300);
		latch_lvl <= 1'b1;
		settle();
		rchk(adg_pkg::ADDR_RESULT_HIGH, 8'h01);
		rchk(adg_pkg::ADDR_RESULT_LOW, 8'h2c);
		rchk(adg_pkg::ADDR_STATUS, 8'h01);
		// Latch line drops first, else the edge detector, whose latch_prev reset clears, sees a fresh edge after reset.
		latch_lvl <= 1'b0;
		settle();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk("reset acc", accumulator, 0);
		rchk(adg_pkg::ADDR_RESULT_HIGH, 8'h01);
		rchk(adg_pkg::ADDR_RESULT_LOW, 8'h2c);
		rchk(adg_pkg::ADDR_STATUS, 8'h00);
		comp_set <= 4'h1;
		repeat (5) @(posedge aclk);
		comp_set <= 4'h0;
		settle();
		chk("short count", accumulator, 5);
		wr(adg_pkg::ADDR_RESULT_LOW, 8'h00);
		chk("clear low", accumulator, 0);
		rd(10'h000);
		chk("bad read resp", resp, adg_pkg::RESP_SLVERR);
		chk("bad read data", word, 32'h0000_0000);
		wr(10'h3f0, 8'hff);
		chk("bad write", resp, adg_pkg::RESP_SLVERR);
		give_verdict();
	end
endmodule // adg_decimator_front_tb_top
`default_nettype wire
